// [tb_top.sv]
// self-checking bench for the endpoint interrupt-enable block
`timescale 1ns/10ps
module tb_top;
  import uep_pkg::*;
  // ==========
  // signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, seen;
  logic dma_req, dma_end, endpoint_irq, short_packet_send, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, stat_req, stat;
  logic [2:0] err_req, err_ev;
  int mismatches, n_checks, i;
  int bp[4] = '{UEP_BIT_OVERFLOW, UEP_BIT_STALLED, UEP_BIT_SHORT_PACKET, UEP_BIT_BUSY_BANK};
  logic [3:0] ctl[4] = '{4'h7, 4'hf, 4'h5, 4'h3};
  uep_host_model u_host (.pclk(pclk), .presetn(presetn), .err_req(err_req), .dma_req(dma_req),
    .stat_req(stat_req), .err_ev(err_ev), .dma_end(dma_end), .stat(stat));
  uep_endpoint_irq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy_bank_count_status(stat[3]),
    .short_packet_status(stat[2]), .stalled_status(stat[1]), .overflow_status(stat[0]),
    .pid_error_event(err_ev[2]), .data_pid_error_event(err_ev[1]),
    .data_toggle_error_event(err_ev[0]), .dma_transfer_end(dma_end),
    .endpoint_irq(endpoint_irq), .short_packet_send(short_packet_send), .irq(irq));
  // ==========
  // tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high, failing the run after 20 cycles without it; no wait-state count assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      mismatches++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic fire(input logic [2:0] e, input logic dma);
    @(posedge pclk);
    err_req <= e;
    dma_req <= dma;
    @(posedge pclk);
    err_req <= 3'h0;
    dma_req <= 1'b0;
    seen = 1'b0;
    repeat (4) begin
      @(posedge pclk);
      seen = seen | short_packet_send;
    end
  endtask
  // ==========
  // clock and sequence
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    err_req = 3'h0;
    dma_req = 1'b0;
    stat_req = 4'h0;
    mismatches = 0;
    n_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(UEP_ADDR_ENABLE, 32'h0);
    rdc(UEP_ADDR_ERR_FLAGS, 32'h0);
    // each enable: set, zero writes ignored, clear
    for (i = 0; i < 4; i++) begin
      wr(UEP_ADDR_ENABLE_SET, 32'h1 << bp[i]);
      wr(UEP_ADDR_ENABLE_SET, 32'h0);
      rdc(UEP_ADDR_ENABLE, 32'h1 << bp[i]);
      wr(UEP_ADDR_ENABLE_CLEAR, 32'h0);
      rdc(UEP_ADDR_ENABLE, 32'h1 << bp[i]);
      wr(UEP_ADDR_ENABLE_CLEAR, 32'h1 << bp[i]);
      rdc(UEP_ADDR_ENABLE, 32'h0);
    end
    // status with a wrong enable set, then matching enable
    for (i = 0; i < 4; i++) begin
      stat_req <= 4'h1 << i;
      wr(UEP_ADDR_ENABLE_SET, 32'h1 << bp[(i + 1) % 4]);
      rdc(UEP_ADDR_STATUS, 32'h1 << bp[i]);
      chk(32'(endpoint_irq), 32'h0);
      wr(UEP_ADDR_ENABLE_SET, 32'h1 << bp[i]);
      repeat (3) @(posedge pclk);
      chk(32'(endpoint_irq), 32'h1);
      wr(UEP_ADDR_ENABLE_CLEAR, 32'h0000_10e0);
    end
    stat_req <= 4'h0;
    wr(UEP_ADDR_IRQ_STATUS, 32'hf);
    // sticky error flags, masked and unmasked interrupt line
    for (i = 0; i < 3; i++) begin
      fire(3'h1 << i, 1'b0);
      rdc(UEP_ADDR_ERR_FLAGS, 32'h1 << i);
      rdc(UEP_ADDR_IRQ_STATUS, 32'h1 << (3 - i));
      chk(32'(irq), 32'h0);
      wr(UEP_ADDR_IRQ_MASK, 32'hf);
      @(posedge pclk);
      chk(32'(irq), 32'h1);
      wr(UEP_ADDR_IRQ_STATUS, 32'hf);
      @(posedge pclk);
      chk(32'(irq), 32'h0);
      wr(UEP_ADDR_IRQ_MASK, 32'h0);
      repeat (5) @(posedge pclk);
      rdc(UEP_ADDR_ERR_FLAGS, 32'h1 << i);
      wr(UEP_ADDR_ERR_CLEAR, 32'h1 << i);
      rdc(UEP_ADDR_ERR_FLAGS, 32'h0);
    end
    // short packet at dma end only for a non-control in endpoint with both bits
    wr(UEP_ADDR_ENABLE_SET, 32'h1 << UEP_BIT_SHORT_PACKET);
    for (i = 0; i < 4; i++) begin
      wr(UEP_ADDR_CTRL, {28'h0, ctl[i]});
      fire(3'h0, 1'b1);
      chk(32'(seen), (i == 0) ? 32'h1 : 32'h0);
    end
    wr(UEP_ADDR_CTRL, 32'h7);
    chk(32'(err), 32'h0);
    wr(UEP_ADDR_ENABLE_CLEAR, 32'h1 << UEP_BIT_SHORT_PACKET);
    fire(3'h0, 1'b1);
    chk(32'(seen), 32'h0);
    // unmapped place refused and write ignored
    wr(8'h40, 32'hffff_ffff);
    chk(32'(err), 32'h1);
    rdc(8'h40, 32'h0);
    rdc(UEP_ADDR_ENABLE, 32'h0);
    give_verdict();
  end
endmodule

// [uep_endpoint_irq.sv]
// endpoint interrupt-enable logic with protocol-error flags, apb slave
`timescale 1ns/10ps
module uep_endpoint_irq
  import uep_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // endpoint status from the transfer engine (same clock)
  input wire logic busy_bank_count_status,
  input wire logic short_packet_status,
  input wire logic stalled_status,
  input wire logic overflow_status,
  // protocol error events, one-cycle pulses
  input wire logic pid_error_event,
  input wire logic data_pid_error_event,
  input wire logic data_toggle_error_event,
  // dma transfer end, one-cycle pulse
  input wire logic dma_transfer_end,
  // outputs
  output logic endpoint_irq,
  output logic short_packet_send,
  output logic irq
);
  // ===========================================================
  // declarations
  uep_apb_state_t apb_state;
  uep_apb_state_t next_apb_state;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [31:0] next_prdata;
  logic busy_bank_irq_enable;
  logic short_packet_irq_enable;
  logic stalled_irq_enable;
  logic overflow_irq_enable;
  logic [3:0] ctrl;
  logic [2:0] err_set;
  logic [2:0] err_clear;
  logic [2:0] err_flags;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [3:0] irq_events;
  logic [3:0] irq_clear;
  logic endpoint_irq_d;
  logic [31:0] ep_status_word;
  logic [31:0] ep_enable_word;
  logic dma_buffer_end_output_enable;
  logic auto_bank_switch;

  function automatic logic [31:0] uep_wmask(input logic [31:0] d, input logic [3:0] s);
    uep_wmask = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic uep_reg_hit(input logic [7:0] a);
    uep_reg_hit = (a == UEP_ADDR_STATUS) || (a == UEP_ADDR_ENABLE) ||
                  (a == UEP_ADDR_ENABLE_SET) || (a == UEP_ADDR_ENABLE_CLEAR) ||
                  (a == UEP_ADDR_ERR_FLAGS) || (a == UEP_ADDR_ERR_CLEAR) ||
                  (a == UEP_ADDR_CTRL) || (a == UEP_ADDR_IRQ_STATUS) ||
                  (a == UEP_ADDR_IRQ_MASK);
  endfunction

  logic [31:0] wdata_m;
  assign wdata_m = uep_wmask(pwdata, pstrb);

  // ===========================================================
  // apb handshake: one wait state, answer in the second access cycle
  always_comb begin
    next_apb_state = apb_state;
    case (apb_state)
      UEP_APB_IDLE: begin
        if (psel && penable) begin
          next_apb_state = UEP_APB_ACCESS;
        end
      end
      UEP_APB_ACCESS: begin
        next_apb_state = UEP_APB_IDLE;
      end
      default: begin
        next_apb_state = UEP_APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state <= UEP_APB_IDLE;
    end else begin
      apb_state <= next_apb_state;
    end
  end

  assign pready = (apb_state == UEP_APB_ACCESS);
  assign hit = uep_reg_hit(paddr);
  assign pslverr = pready && !hit;
  assign wr_en = psel && penable && pready && pwrite && hit;
  // read data is captured one cycle ahead of pready so it stands in the answering cycle
  assign rd_en = psel && penable && !pready && !pwrite;

  // ===========================================================
  // enable bits: only a written 1 acts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_bank_irq_enable <= 1'b0;
      short_packet_irq_enable <= 1'b0;
      stalled_irq_enable <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end else if (wr_en && paddr == UEP_ADDR_ENABLE_SET) begin
      // set has no clear partner in the same write, so order is moot
      if (wdata_m[UEP_BIT_BUSY_BANK]) begin
        busy_bank_irq_enable <= 1'b1;
      end
      if (wdata_m[UEP_BIT_SHORT_PACKET]) begin
        short_packet_irq_enable <= 1'b1;
      end
      if (wdata_m[UEP_BIT_STALLED]) begin
        stalled_irq_enable <= 1'b1;
      end
      if (wdata_m[UEP_BIT_OVERFLOW]) begin
        overflow_irq_enable <= 1'b1;
      end
    end else if (wr_en && paddr == UEP_ADDR_ENABLE_CLEAR) begin
      // clear acts on a written 1, like its siblings
      if (wdata_m[UEP_BIT_BUSY_BANK]) begin
        busy_bank_irq_enable <= 1'b0;
      end
      if (wdata_m[UEP_BIT_SHORT_PACKET]) begin
        short_packet_irq_enable <= 1'b0;
      end
      if (wdata_m[UEP_BIT_STALLED]) begin
        stalled_irq_enable <= 1'b0;
      end
      if (wdata_m[UEP_BIT_OVERFLOW]) begin
        overflow_irq_enable <= 1'b0;
      end
    end
  end

  // ===========================================================
  // endpoint configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= UEP_RESET_CTRL;
    end else if (wr_en && paddr == UEP_ADDR_CTRL) begin
      ctrl <= wdata_m[3:0];
    end
  end
  assign dma_buffer_end_output_enable = ctrl[UEP_BIT_DMA_END_OE];
  assign auto_bank_switch = ctrl[UEP_BIT_AUTO_SWITCH];

  // ===========================================================
  // endpoint interrupt and short packet request
  always_comb begin
    endpoint_irq_d = (busy_bank_count_status && busy_bank_irq_enable) ||
                     (short_packet_status && short_packet_irq_enable) ||
                     (stalled_status && stalled_irq_enable) ||
                     (overflow_status && overflow_irq_enable);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      endpoint_irq <= 1'b0;
      short_packet_send <= 1'b0;
    end else begin
      endpoint_irq <= endpoint_irq_d;
      short_packet_send <= dma_transfer_end && short_packet_irq_enable &&
                           ctrl[UEP_BIT_IN_EP] && !ctrl[UEP_BIT_CONTROL_EP] &&
                           dma_buffer_end_output_enable && auto_bank_switch;
    end
  end

  // ===========================================================
  // protocol error flags
  assign err_set[UEP_BIT_PID_ERR] = pid_error_event;
  assign err_set[UEP_BIT_DATA_PID_ERR] = data_pid_error_event;
  assign err_set[UEP_BIT_DATA_TOGGLE_ERR] = data_toggle_error_event;
  assign err_clear = (wr_en && paddr == UEP_ADDR_ERR_CLEAR) ? wdata_m[2:0] : UEP_RESET_ERR;

  uep_flag_bank #(
    .WIDTH(3)
  ) u_err_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_pulse(err_set),
    .clear_pulse(err_clear),
    .flags(err_flags)
  );

  // ===========================================================
  // interrupt status, mask and line
  logic endpoint_irq_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      endpoint_irq_q <= 1'b0;
    end else begin
      endpoint_irq_q <= endpoint_irq;
    end
  end
  assign irq_events = {data_toggle_error_event, data_pid_error_event, pid_error_event,
                       endpoint_irq && !endpoint_irq_q};
  assign irq_clear = (wr_en && paddr == UEP_ADDR_IRQ_STATUS) ?
                     wdata_m[UEP_IRQ_WIDTH-1:0] : UEP_RESET_IRQ;

  uep_flag_bank #(
    .WIDTH(UEP_IRQ_WIDTH)
  ) u_irq_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set_pulse(irq_events),
    .clear_pulse(irq_clear),
    .flags(irq_status)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= UEP_RESET_IRQ;
    end else if (wr_en && paddr == UEP_ADDR_IRQ_MASK) begin
      irq_mask <= wdata_m[UEP_IRQ_WIDTH-1:0];
    end
  end
  assign irq = |(irq_status & irq_mask);

  // ===========================================================
  // read data
  always_comb begin
    ep_status_word = UEP_RESET_WORD;
    ep_status_word[UEP_BIT_BUSY_BANK] = busy_bank_count_status;
    ep_status_word[UEP_BIT_SHORT_PACKET] = short_packet_status;
    ep_status_word[UEP_BIT_STALLED] = stalled_status;
    ep_status_word[UEP_BIT_OVERFLOW] = overflow_status;
    ep_enable_word = UEP_RESET_WORD;
    ep_enable_word[UEP_BIT_BUSY_BANK] = busy_bank_irq_enable;
    ep_enable_word[UEP_BIT_SHORT_PACKET] = short_packet_irq_enable;
    ep_enable_word[UEP_BIT_STALLED] = stalled_irq_enable;
    ep_enable_word[UEP_BIT_OVERFLOW] = overflow_irq_enable;
    next_prdata = UEP_RESET_WORD;
    if (paddr == UEP_ADDR_STATUS) begin
      next_prdata = ep_status_word;
    end else if (paddr == UEP_ADDR_ENABLE) begin
      next_prdata = ep_enable_word;
    end else if (paddr == UEP_ADDR_ERR_FLAGS) begin
      next_prdata[2:0] = err_flags;
    end else if (paddr == UEP_ADDR_CTRL) begin
      next_prdata[3:0] = ctrl;
    end else if (paddr == UEP_ADDR_IRQ_STATUS) begin
      next_prdata[UEP_IRQ_WIDTH-1:0] = irq_status;
    end else if (paddr == UEP_ADDR_IRQ_MASK) begin
      next_prdata[UEP_IRQ_WIDTH-1:0] = irq_mask;
    end
  end

  // prdata registered so it stands stable through the answering cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= UEP_RESET_WORD;
    end else if (rd_en) begin
      prdata <= next_prdata;
    end
  end

  // ===========================================================
  // assertions
  sequence set_write_s(int b);
    wr_en && paddr == UEP_ADDR_ENABLE_SET && wdata_m[b];
  endsequence
  sequence clear_write_s(int b);
    wr_en && paddr == UEP_ADDR_ENABLE_CLEAR && wdata_m[b];
  endsequence

  busy_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_write_s(UEP_BIT_BUSY_BANK) |=> busy_bank_irq_enable)
    else $error("busy bank enable not set");
  busy_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    clear_write_s(UEP_BIT_BUSY_BANK) |=> !busy_bank_irq_enable)
    else $error("busy bank enable not cleared");
  short_en_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_write_s(UEP_BIT_SHORT_PACKET) |=> short_packet_irq_enable)
    else $error("short packet enable not set");
  short_send_a: assert property (@(posedge pclk) disable iff (!presetn)
    short_packet_send |-> $past(dma_transfer_end) && $past(auto_bank_switch) &&
    $past(dma_buffer_end_output_enable) && $past(short_packet_irq_enable) &&
    $past(ctrl[UEP_BIT_IN_EP]) && !$past(ctrl[UEP_BIT_CONTROL_EP]))
    else $error("short packet sent without cause");
  stalled_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    clear_write_s(UEP_BIT_STALLED) |=> !stalled_irq_enable)
    else $error("stalled enable not cleared");
  overflow_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_write_s(UEP_BIT_OVERFLOW) |=> overflow_irq_enable)
    else $error("overflow enable not set");
  pid_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    pid_error_event |=> err_flags[UEP_BIT_PID_ERR])
    else $error("pid error flag not set");
  dpid_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    data_pid_error_event |=> err_flags[UEP_BIT_DATA_PID_ERR])
    else $error("data pid flag not set");
  toggle_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    data_toggle_error_event |=> err_flags[UEP_BIT_DATA_TOGGLE_ERR])
    else $error("toggle flag not set");
  flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    err_flags[UEP_BIT_PID_ERR] && !err_clear[UEP_BIT_PID_ERR] |=> err_flags[UEP_BIT_PID_ERR])
    else $error("pid flag dropped without clear");
  ep_irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    endpoint_irq |-> $past(endpoint_irq_d))
    else $error("endpoint interrupt without enabled status");
  short_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    clear_write_s(UEP_BIT_SHORT_PACKET) |=> !short_packet_irq_enable)
    else $error("short packet enable not cleared");
  stalled_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_write_s(UEP_BIT_STALLED) |=> stalled_irq_enable)
    else $error("stalled enable not set");
  overflow_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    clear_write_s(UEP_BIT_OVERFLOW) |=> !overflow_irq_enable)
    else $error("overflow enable not cleared");
  zero_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && (paddr == UEP_ADDR_ENABLE_SET || paddr == UEP_ADDR_ENABLE_CLEAR) &&
    wdata_m == UEP_RESET_WORD |=> $stable(ep_enable_word))
    else $error("zero write changed an enable");
  short_need_a: assert property (@(posedge pclk) disable iff (!presetn)
    dma_transfer_end && short_packet_irq_enable && ctrl[UEP_BIT_IN_EP] && !ctrl[UEP_BIT_CONTROL_EP] &&
    dma_buffer_end_output_enable && auto_bank_switch |=> short_packet_send)
    else $error("short packet not sent at dma end");
endmodule

// [uep_flag_bank.sv]
// sticky flag bank: hardware set wins over write-one clear
`timescale 1ns/10ps
module uep_flag_bank #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // events and clears
  input wire logic [WIDTH-1:0] set_pulse,
  input wire logic [WIDTH-1:0] clear_pulse,
  // state
  output logic [WIDTH-1:0] flags
);
  // ===========================================================
  // flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~clear_pulse) | set_pulse;
    end
  end
endmodule

// [uep_host_model.sv]
// model of the bus-side host that stirs endpoint status and protocol errors
`timescale 1ns/10ps
module uep_host_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requests from the bench
  input wire logic [2:0] err_req,
  input wire logic dma_req,
  input wire logic [3:0] stat_req,
  // endpoint side
  output logic [2:0] err_ev,
  output logic dma_end,
  output logic [3:0] stat
);
  // ==========
  // registered so every event is a clean one-cycle pulse on the same clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_ev <= 3'h0;
      dma_end <= 1'b0;
      stat <= 4'h0;
    end else begin
      err_ev <= err_req;
      dma_end <= dma_req;
      stat <= stat_req;
    end
  end
endmodule

// [uep_pkg.sv]
// package for the usb endpoint interrupt-enable and error-flag block
package uep_pkg;
  // ===========================================================
  // register byte offsets
  localparam logic [7:0] UEP_ADDR_STATUS = 8'h00;
  localparam logic [7:0] UEP_ADDR_ENABLE = 8'h04;
  localparam logic [7:0] UEP_ADDR_ENABLE_SET = 8'h08;
  localparam logic [7:0] UEP_ADDR_ENABLE_CLEAR = 8'h0c;
  localparam logic [7:0] UEP_ADDR_ERR_FLAGS = 8'h10;
  localparam logic [7:0] UEP_ADDR_ERR_CLEAR = 8'h14;
  localparam logic [7:0] UEP_ADDR_CTRL = 8'h18;
  localparam logic [7:0] UEP_ADDR_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] UEP_ADDR_IRQ_MASK = 8'h20;
  // ===========================================================
  // bit positions in status / enable / set / clear registers
  localparam int UEP_BIT_OVERFLOW = 5;
  localparam int UEP_BIT_STALLED = 6;
  localparam int UEP_BIT_SHORT_PACKET = 7;
  localparam int UEP_BIT_BUSY_BANK = 12;
  // error flag positions
  localparam int UEP_BIT_DATA_TOGGLE_ERR = 0;
  localparam int UEP_BIT_DATA_PID_ERR = 1;
  localparam int UEP_BIT_PID_ERR = 2;
  // control register positions
  localparam int UEP_BIT_DMA_END_OE = 0;
  localparam int UEP_BIT_AUTO_SWITCH = 1;
  localparam int UEP_BIT_IN_EP = 2;
  localparam int UEP_BIT_CONTROL_EP = 3;
  // interrupt summary register positions
  localparam int UEP_IRQ_ENDPOINT = 0;
  localparam int UEP_IRQ_PID_ERR = 1;
  localparam int UEP_IRQ_DATA_PID_ERR = 2;
  localparam int UEP_IRQ_TOGGLE_ERR = 3;
  localparam int UEP_IRQ_WIDTH = 4;
  // ===========================================================
  // reset values
  localparam logic [31:0] UEP_RESET_WORD = 32'h0000_0000;
  localparam logic [3:0] UEP_RESET_IRQ = 4'h0;
  localparam logic [2:0] UEP_RESET_ERR = 3'h0;
  localparam logic [3:0] UEP_RESET_EN = 4'h0;
  localparam logic [3:0] UEP_RESET_CTRL = 4'h0;
  // apb slave states (gray order idle -> access)
  typedef enum logic [1:0] {
    UEP_APB_IDLE = 2'b00,
    UEP_APB_ACCESS = 2'b01
  } uep_apb_state_t;
endpackage
